/* File: core/mpod_consts.vh */
// Purpose: constants for the motor parameter loader and decoder
// Assumes: 32-bit classic Wishbone slave, word aligned registers
// Notes:   offsets are byte addresses
`ifndef MPOD_CONSTS_VH
`define MPOD_CONSTS_VH
// Register byte offsets
`define MPOD_OFF_CTRL     8'h00
`define MPOD_OFF_PARAM    8'h04
`define MPOD_OFF_SAFE     8'h08
`define MPOD_OFF_STATUS   8'h0C
`define MPOD_OFF_NVRD     8'h10
`define MPOD_OFF_DRIVE    8'h14
// Non-volatile byte indices
`define MPOD_NV_BANK      4'h1
`define MPOD_NV_THR_ADDR  4'h2
`define MPOD_NV_CURR      4'h3
`define MPOD_NV_SPEED     4'h4
`define MPOD_NV_SAFE_HI   4'h5
`define MPOD_NV_SAFE_LO   4'h6
`define MPOD_NV_MODE      4'h7
`define MPOD_NV_ALT_HI    4'h8
`define MPOD_NV_ALT_LO    4'h9
// Field positions
`define MPOD_BANK_BIT     7
// Safe position disable pattern on bits [10:2]
`define MPOD_SAFE_OFF     9'h100
// Hold code meaning zero hold current
`define MPOD_HOLD_ZERO    4'hF
// Reset values
`define MPOD_RST_ZERO     32'h0000_0000
// Dwell at minimum current before regulator shutoff
`define MPOD_DWELL_NS     1000
`define MPOD_CLK_NS       25
`define MPOD_DWELL_CYC    ((`MPOD_DWELL_NS + `MPOD_CLK_NS - 1) / `MPOD_CLK_NS)
`endif

/* File: core/mpod_top.v */
// Purpose: load, decode and apply stored motor application parameters
// Assumes: nvm image arrives as ten parallel bytes, stable after reset
// Notes:   analog levels leave as table indices and decoded codes
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "mpod_consts.vh"
module mpod_top #(
	parameter DWELL_CYC = `MPOD_DWELL_CYC
) (
	// Clock and reset
	input  wire        clk_in,
	input  wire        srst_in,
	// Wishbone slave
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	// Non-volatile image, bytes 0 to 9 packed low first
	input  wire [79:0] nvm_image_in,
	// Hardwired address pins, from outside
	input  wire [2:0]  hardwired_addr_pins_in,
	// Motion controller events, same clock
	input  wire        motion_stop_in,
	input  wire        bus_timeout_in,
	input  wire        bus_err_ovf_in,
	input  wire        sleep_cmd_in,
	input  wire        goto_safe_position_in,
	input  wire        standby_state_in,
	// Decoded outputs
	output reg  [7:0]  node_addr_out,
	output reg         stall_detect_en_out,
	output reg  [3:0]  bemf_stall_threshold_out,
	output reg  [2:0]  low_battery_level_out,
	output reg  [2:0]  battery_recovery_level_out,
	output reg  [3:0]  coil_amp_code_out,
	output reg         coil_amp_boost_out,
	output reg         regulator_on_out,
	output reg         low_side_ground_out,
	output reg         shaft_ccw_out,
	output reg  [4:0]  microsteps_out,
	output reg  [3:0]  speed_max_code_out,
	output reg  [1:0]  speed_group_out,
	output reg  [4:0]  speed_min_num_out,
	output reg  [3:0]  accel_code_out,
	output reg         accel_limited_out,
	output reg  [15:0] safe_target_position_out,
	output reg         goto_target_out,
	output reg         hold_in_place_out,
	output reg         sleep_req_out,
	output reg         stop_req_out,
	output reg         params_ready_out
);

	// Synchronised address pins; first stage read only by second
	reg [2:0] addr_meta;
	reg [2:0] addr_sync;

	// Working RAM copies of parameters
	reg [3:0]  node_addr_bits;
	reg [3:0]  stall_thr;
	reg [2:0]  undervolt_threshold_sel;
	reg [3:0]  run_code;
	reg [3:0]  hold_code;
	reg [3:0]  vmax_code;
	reg [3:0]  vmin_code;
	reg [3:0]  acc_code;
	reg        shaft;
	reg [1:0]  microstep_resolution;
	reg [10:0] safe_pos;
	reg        failsafe;
	reg        sleep_on_timeout_enable;
	reg        boost_en;
	reg        safe_bank_select;
	reg        loaded;
	reg [3:0]  nv_rd_idx;

	// Current sequencer states, one-hot
	localparam [2:0] MPOD_ST_RUN  = 3'b001;
	localparam [2:0] MPOD_ST_MIN  = 3'b010;
	localparam [2:0] MPOD_ST_HOLD = 3'b100;
	reg [2:0]  cur_state;
	reg [15:0] dwell;

	// Byte picker from the packed image
	function [7:0] nv_byte;
		input [79:0] img;
		input [3:0]  idx;
		begin
			nv_byte = img[idx*8 +: 8];
		end
	endfunction

	// Byte read with bank redirection for indices five and six
	function [7:0] nv_read;
		input [79:0] img;
		input [3:0]  idx;
		input        bank;
		begin
			nv_read = (idx > `MPOD_NV_ALT_LO) ? 8'h00 :
				nv_byte(img, (bank && (idx == `MPOD_NV_SAFE_HI ||
				idx == `MPOD_NV_SAFE_LO)) ?
				idx + (`MPOD_NV_ALT_HI - `MPOD_NV_SAFE_HI) : idx);
		end
	endfunction

	// Bank-selected safe bytes
	wire [7:0] b1      = nv_byte(nvm_image_in, `MPOD_NV_BANK);
	wire       nv_bank = b1[`MPOD_BANK_BIT];
	wire [7:0] nv_hi   = nv_bank ?
		nv_byte(nvm_image_in, `MPOD_NV_ALT_HI) :
		nv_byte(nvm_image_in, `MPOD_NV_SAFE_HI);
	wire [7:0] nv_lo   = nv_bank ?
		nv_byte(nvm_image_in, `MPOD_NV_ALT_LO) :
		nv_byte(nvm_image_in, `MPOD_NV_SAFE_LO);
	wire [7:0] b2 = nv_byte(nvm_image_in, `MPOD_NV_THR_ADDR);
	wire [7:0] b3 = nv_byte(nvm_image_in, `MPOD_NV_CURR);
	wire [7:0] b4 = nv_byte(nvm_image_in, `MPOD_NV_SPEED);
	wire [7:0] b5 = nv_byte(nvm_image_in, `MPOD_NV_SAFE_HI);
	wire [7:0] b7 = nv_byte(nvm_image_in, `MPOD_NV_MODE);

	// Bus access decode
	wire bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	wire wr_param = bus_req && wb_we_in && wb_adr_in == `MPOD_OFF_PARAM;
	wire wr_safe  = bus_req && wb_we_in && wb_adr_in == `MPOD_OFF_SAFE;
	wire wr_ctrl  = bus_req && wb_we_in && wb_adr_in == `MPOD_OFF_CTRL;
	wire wr_nvrd  = bus_req && wb_we_in && wb_adr_in == `MPOD_OFF_NVRD;

	// Address pins cross in through two flops
	always @(posedge clk_in) begin
		if (srst_in) begin
			addr_meta <= 3'h0;
			addr_sync <= 3'h0;
		end else begin
			addr_meta <= hardwired_addr_pins_in;
			addr_sync <= addr_meta;
		end
	end

	// Parameter RAM: loaded once after reset, then bus may overwrite
	always @(posedge clk_in) begin
		if (srst_in) begin
			loaded                  <= 1'b0;
			node_addr_bits          <= 4'h0;
			stall_thr               <= 4'h0;
			undervolt_threshold_sel <= 3'h0;
			run_code                <= 4'h0;
			hold_code               <= 4'h0;
			vmax_code               <= 4'h0;
			vmin_code               <= 4'h0;
			acc_code                <= 4'h0;
			shaft                   <= 1'b0;
			microstep_resolution    <= 2'h0;
			safe_pos                <= 11'h000;
			failsafe                <= 1'b0;
			sleep_on_timeout_enable <= 1'b0;
			safe_bank_select        <= 1'b0;
			boost_en                <= 1'b0;
			nv_rd_idx               <= 4'h0;
		end else if (!loaded) begin
			// Image sampled after reset release, never under reset
			loaded                  <= 1'b1;
			node_addr_bits          <= b2[3:0];
			stall_thr               <= b2[7:4];
			undervolt_threshold_sel <= b7[6:4];
			run_code                <= b3[7:4];
			hold_code               <= b3[3:0];
			vmax_code               <= b4[7:4];
			vmin_code               <= b4[3:0];
			acc_code                <= b5[3:0];
			shaft                   <= b5[4];
			microstep_resolution    <= b7[3:2];
			safe_pos <= {nv_hi[7:5], nv_lo[7:2], 2'b00};
			failsafe                <= nv_lo[1];
			sleep_on_timeout_enable <= nv_lo[0];
			safe_bank_select        <= nv_bank;
		end else begin
			// Address bits are not reachable from the bus
			if (wr_param && wb_sel_in[0]) begin
				run_code  <= wb_dat_in[7:4];
				hold_code <= wb_dat_in[3:0];
			end
			if (wr_param && wb_sel_in[1]) begin
				vmax_code <= wb_dat_in[15:12];
				vmin_code <= wb_dat_in[11:8];
			end
			if (wr_param && wb_sel_in[2]) begin
				acc_code  <= wb_dat_in[19:16];
				stall_thr <= wb_dat_in[23:20];
			end
			if (wr_param && wb_sel_in[3]) begin
				undervolt_threshold_sel <= wb_dat_in[26:24];
				microstep_resolution    <= wb_dat_in[28:27];
				shaft                   <= wb_dat_in[29];
			end
			if (wr_safe && wb_sel_in[1:0] == 2'h3) begin
				safe_pos <= wb_dat_in[10:0];
			end
			if (wr_ctrl && wb_sel_in[0]) begin
				boost_en <= wb_dat_in[0];
			end
			if (wr_nvrd && wb_sel_in[0]) begin
				nv_rd_idx <= wb_dat_in[3:0];
			end
		end
	end

	// Bus slave: one wait-free ack, unmapped reads return zero
	always @(posedge clk_in) begin
		if (srst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= `MPOD_RST_ZERO;
		end else begin
			wb_ack_out <= bus_req;
			wb_dat_out <= `MPOD_RST_ZERO;
			if (bus_req && !wb_we_in) begin
				case (wb_adr_in)
				`MPOD_OFF_CTRL: begin
					wb_dat_out <= {31'h0, boost_en};
				end
				`MPOD_OFF_PARAM: begin
					wb_dat_out <= {2'h0, shaft, microstep_resolution,
						undervolt_threshold_sel, stall_thr, acc_code,
						vmax_code, vmin_code, run_code, hold_code};
				end
				`MPOD_OFF_SAFE: begin
					wb_dat_out <= {21'h0, safe_pos};
				end
				`MPOD_OFF_STATUS: begin
					wb_dat_out <= {16'h0, node_addr_out, 1'b0, cur_state,
						safe_bank_select, failsafe,
						sleep_on_timeout_enable, loaded};
				end
				`MPOD_OFF_NVRD: begin
					wb_dat_out <= {20'h0, nv_rd_idx,
						nv_read(nvm_image_in, nv_rd_idx,
						safe_bank_select)};
				end
				`MPOD_OFF_DRIVE: begin
					wb_dat_out <= {27'h0, sleep_req_out, stop_req_out,
						hold_in_place_out, goto_target_out,
						regulator_on_out};
				end
				default: begin
					wb_dat_out <= `MPOD_RST_ZERO;
				end
				endcase
			end
		end
	end

	// Coil current sequencer for stop with optional zero hold
	always @(posedge clk_in) begin
		if (srst_in) begin
			cur_state <= MPOD_ST_RUN;
			dwell     <= 16'h0000;
		end else begin
			case (cur_state)
			MPOD_ST_RUN: begin
				if (motion_stop_in && hold_code == `MPOD_HOLD_ZERO) begin
					cur_state <= MPOD_ST_MIN;
					dwell     <= 16'h0000;
				end else if (motion_stop_in) begin
					cur_state <= MPOD_ST_HOLD;
				end
			end
			MPOD_ST_MIN: begin
				// Dwell lets the coil settle at minimum before release
				if (dwell >= DWELL_CYC[15:0] - 16'h0001) begin
					cur_state <= MPOD_ST_HOLD;
				end else begin
					dwell <= dwell + 16'h0001;
				end
			end
			MPOD_ST_HOLD: begin
				if (!motion_stop_in) begin
					cur_state <= MPOD_ST_RUN;
				end
			end
			default: begin
				cur_state <= MPOD_ST_RUN;
			end
			endcase
		end
	end

	// Decoded outputs, registered
	always @(posedge clk_in) begin
		if (srst_in) begin
			node_addr_out              <= 8'h00;
			stall_detect_en_out        <= 1'b0;
			bemf_stall_threshold_out   <= 4'h0;
			low_battery_level_out      <= 3'h0;
			battery_recovery_level_out <= 3'h0;
			coil_amp_code_out          <= 4'h0;
			coil_amp_boost_out         <= 1'b0;
			regulator_on_out           <= 1'b0;
			low_side_ground_out        <= 1'b0;
			shaft_ccw_out              <= 1'b0;
			microsteps_out             <= 5'h02;
			speed_max_code_out         <= 4'h0;
			speed_group_out            <= 2'h0;
			speed_min_num_out          <= 5'h00;
			accel_code_out             <= 4'h0;
			accel_limited_out          <= 1'b0;
			safe_target_position_out   <= 16'h0000;
			goto_target_out            <= 1'b0;
			hold_in_place_out          <= 1'b0;
			sleep_req_out              <= 1'b0;
			stop_req_out               <= 1'b0;
			params_ready_out           <= 1'b0;
		end else begin
			params_ready_out <= loaded;
			node_addr_out <= {1'b0, node_addr_bits, addr_sync};
			stall_detect_en_out      <= stall_thr != 4'h0;
			bemf_stall_threshold_out <= stall_thr;
			// Recovery index tracks the low level index
			low_battery_level_out      <= undervolt_threshold_sel;
			battery_recovery_level_out <= undervolt_threshold_sel;
			coil_amp_boost_out <= boost_en;
			// Running drive unless a stop state below takes over
			coil_amp_code_out   <= run_code;
			regulator_on_out    <= 1'b1;
			low_side_ground_out <= 1'b0;
			case (cur_state)
			MPOD_ST_MIN: begin
				coil_amp_code_out <= 4'h0;
			end
			MPOD_ST_HOLD: begin
				if (hold_code == `MPOD_HOLD_ZERO) begin
					coil_amp_code_out   <= 4'h0;
					regulator_on_out    <= 1'b0;
					low_side_ground_out <= 1'b1;
				end else begin
					coil_amp_code_out <= hold_code;
				end
			end
			default: begin
				coil_amp_code_out <= run_code;
			end
			endcase
			shaft_ccw_out  <= shaft;
			microsteps_out <= 5'h02 << microstep_resolution;
			speed_max_code_out <= vmax_code;
			speed_group_out <= (vmax_code == 4'h0) ? 2'h0 :
				(vmax_code < 4'h7) ? 2'h1 :
				(vmax_code < 4'hD) ? 2'h2 : 2'h3;
			// Numerator over 16; code zero means full factor
			speed_min_num_out <= (vmin_code == 4'h0) ? 5'h10 :
				{1'b0, vmin_code};
			accel_code_out    <= acc_code;
			accel_limited_out <= acc_code < 4'h2 || acc_code > 4'h8;
			safe_target_position_out <= {safe_pos, 5'h00};
			// Explicit command ignores disable pattern
			goto_target_out <= goto_safe_position_in ||
				((bus_timeout_in || bus_err_ovf_in) &&
				safe_pos[10:2] != `MPOD_SAFE_OFF);
			hold_in_place_out <= (bus_timeout_in || bus_err_ovf_in) &&
				safe_pos[10:2] == `MPOD_SAFE_OFF &&
				!goto_safe_position_in;
			sleep_req_out <= (bus_timeout_in && sleep_on_timeout_enable)
				|| (sleep_cmd_in && sleep_on_timeout_enable)
				|| ((bus_timeout_in || sleep_cmd_in) &&
				standby_state_in);
			stop_req_out <= sleep_cmd_in && !sleep_on_timeout_enable &&
				!standby_state_in;
		end
	end

endmodule

/* File: sim/mpod_chk.sv */
// Purpose: port assertions for the parameter decoder
// Assumes: one clock domain, synchronous active high reset
// Notes:   decode relations wait for params_ready_out
`timescale 1ns/1ps
module mpod_chk (
	// Clock, reset and bus handshake
	input wire		clk_in,
	input wire		srst_in,
	input wire		wb_cyc_in,
	input wire		wb_stb_in,
	input wire		wb_ack_out,
	// Decoded outputs under watch
	input wire		params_ready_out,
	input wire		stall_detect_en_out,
	input wire [3:0]	bemf_stall_threshold_out,
	input wire [3:0]	coil_amp_code_out,
	input wire		regulator_on_out,
	input wire		low_side_ground_out,
	input wire [4:0]	microsteps_out,
	input wire [3:0]	accel_code_out,
	input wire		accel_limited_out,
	input wire [15:0]	safe_target_position_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Unanswered request gets its ack on the very next edge
	a_ack_follows: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out) else $error("request not answered");
	// Ack never stretches past one cycle
	a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held high");
	// Stored values are in force two edges after reset release
	a_ready_after: assert property ($fell(srst_in) |-> ##[1:2] params_ready_out)
		else $error("parameters not loaded");
	// Threshold code zero switches motion detection off
	a_stall_off: assert property (params_ready_out |->
		stall_detect_en_out == (bemf_stall_threshold_out != 4'h0))
		else $error("stall enable wrong");
	// Bridge grounding only follows a stretch at minimum current
	a_min_first: assert property ($rose(low_side_ground_out) |->
		$past(regulator_on_out) && $past(coil_amp_code_out) == 4'h0
		&& !regulator_on_out) else $error("zero hold sequence wrong");
	// Low bits of the safe position are always zero
	a_safe_low: assert property (safe_target_position_out[4:0] == 5'h00)
		else $error("safe position low bits set");
	// Only the four resolutions exist
	a_step_res: assert property (microsteps_out inside
		{5'h02, 5'h04, 5'h08, 5'h10}) else $error("bad resolution");
	// Speed restriction flag for the steep ramp codes
	a_accel_lim: assert property (params_ready_out |-> accel_limited_out
		== (accel_code_out < 4'h2 || accel_code_out > 4'h8))
		else $error("ramp limit flag wrong");
endmodule
bind mpod_top mpod_chk i_mpod_chk (.clk_in, .srst_in, .wb_cyc_in,
	.wb_stb_in, .wb_ack_out, .params_ready_out, .stall_detect_en_out,
	.bemf_stall_threshold_out, .coil_amp_code_out, .regulator_on_out,
	.low_side_ground_out, .microsteps_out, .accel_code_out,
	.accel_limited_out, .safe_target_position_out);

/* File: sim/mpod_lin_master.sv */
// Purpose: register bus master in place of the bus node controller
// Assumes: classic single cycle, slave answers with registered ack
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module mpod_lin_master (
	// Clock and slave answer
	input  wire		clk_in,
	input  wire		ack_in,
	input  wire [31:0]	dat_in,
	// Request lines
	output reg		cyc_out = 1'b0,
	output reg		stb_out = 1'b0,
	output reg		we_out = 1'b0,
	output reg [7:0]	adr_out = 8'h00,
	output reg [3:0]	sel_out = 4'h0,
	output reg [31:0]	dat_out = 32'h0
);
	// One transfer, everything held until ack is sampled high
	task xfer(input [7:0] a, input w, input [3:0] s, input [31:0] d,
		output [31:0] q);
		@(posedge clk_in);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= w;
		adr_out <= a;
		sel_out <= s;
		dat_out <= d;
		@(posedge clk_in);
		while (ack_in !== 1'b1) @(posedge clk_in);
		q = dat_in;
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		adr_out <= ~a;
		dat_out <= ~d;
	endtask
endmodule

/* File: sim/motor_param_otp_decode_test.sv */
// Purpose: self-checking bench for the parameter decoder
// Assumes: partner master drives the register bus
// Notes:   dwell cut to two cycles so stop tests stay short
`timescale 1ns/1ps
module motor_param_otp_decode_test;
	// Clock, reset, storage image and events
	logic		clk_in = 1'b0;
	logic		srst_in = 1'b1;
	logic [79:0]	nvm_image_in = 80'h0;
	logic [2:0]	hardwired_addr_pins_in = 3'h0;
	logic		motion_stop_in = 1'b0, bus_timeout_in = 1'b0;
	logic		bus_err_ovf_in = 1'b0, sleep_cmd_in = 1'b0;
	logic		goto_safe_position_in = 1'b0, standby_state_in = 1'b0;
	// Bus and decoded outputs
	wire		wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	wire [7:0]	wb_adr_in, node_addr_out;
	wire [31:0]	wb_dat_in, wb_dat_out;
	wire [3:0]	wb_sel_in, bemf_stall_threshold_out, coil_amp_code_out;
	wire [3:0]	speed_max_code_out, accel_code_out;
	wire [2:0]	low_battery_level_out, battery_recovery_level_out;
	wire [4:0]	microsteps_out, speed_min_num_out;
	wire [1:0]	speed_group_out;
	wire [15:0]	safe_target_position_out;
	wire		stall_detect_en_out, coil_amp_boost_out, regulator_on_out;
	wire		low_side_ground_out, shaft_ccw_out, accel_limited_out;
	wire		goto_target_out, hold_in_place_out, sleep_req_out;
	wire		stop_req_out, params_ready_out;
	// Model: parameter word in bus layout, safe position, flags
	logic [7:0]	nv [10];
	logic [31:0]	q, r, p;
	logic [10:0]	m_safe;
	int		m_bank, m_sleep, m_boost, m_addr, seen, k, i;
	int		err_count = 0, check_count = 0, cycles = 0;

	always #12.5 clk_in = ~clk_in;

	mpod_top #(.DWELL_CYC(2)) i_mpod_top (.*);
	mpod_lin_master i_mpod_lin_master (.clk_in, .ack_in(wb_ack_out),
		.dat_in(wb_dat_out), .cyc_out(wb_cyc_in), .stb_out(wb_stb_in),
		.we_out(wb_we_in), .adr_out(wb_adr_in), .sel_out(wb_sel_in),
		.dat_out(wb_dat_in));

	// Compare one value, count it, report a mismatch
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [7:0] a, input [3:0] s, input [31:0] d);
		int b;
		i_mpod_lin_master.xfer(a, 1'b1, s, d, q);
		for (b = 0; b < 4; b++)
			if (a == 8'h04 && s[b]) p[8*b +: 8] = d[8*b +: 8];
	endtask
	task rd(input [7:0] a);
		i_mpod_lin_master.xfer(a, 1'b0, 4'hF, 32'h0, q);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Only waits the given number of cycles, raises no event
	task pulse_tmo(input int n);
		tick(n);
	endtask
	// Decoded parameter outputs, not event outputs, against the model while running
	task check_all;
		chk("addr", node_addr_out, {m_addr[3:0], hardwired_addr_pins_in});
		chk("sten", stall_detect_en_out, p[23:20] != 0);
		chk("thr", bemf_stall_threshold_out, p[23:20]);
		chk("uv", low_battery_level_out, p[26:24]);
		chk("uv1", battery_recovery_level_out, p[26:24]);
		chk("amp", coil_amp_code_out, p[7:4]);
		chk("boost", coil_amp_boost_out, m_boost);
		chk("shaft", shaft_ccw_out, p[29]);
		chk("steps", microsteps_out, 2 << p[28:27]);
		chk("vmax", speed_max_code_out, p[15:12]);
		chk("grp", speed_group_out, p[15:12] == 0 ? 0 : p[15:12] < 7 ? 1 :
			p[15:12] < 13 ? 2 : 3);
		chk("vmin", speed_min_num_out, p[11:8] == 0 ? 16 : p[11:8]);
		chk("acc", accel_code_out, p[19:16]);
		chk("lim", accel_limited_out, p[19:16] < 2 || p[19:16] > 8);
		chk("safe", safe_target_position_out, {m_safe, 5'h00});
	endtask

	// Main sequence: four loads cover every resolution and both banks
	initial begin
		void'($urandom(32'h4361));
		m_boost = 0;
		for (k = 0; k < 4; k++) begin
			for (i = 0; i < 10; i++) nv[i] = $urandom;
			nv[1][7] = k[0];
			nv[7][3:2] = k[1:0];
			if (k == 0) nv[2][7:4] = 4'h0;
			if (k == 2) nv[5][7:5] = 3'b100;
			if (k == 2) nv[6][7:2] = 6'h00;
			// Unused bank holds the opposite sleep flag
			nv[6][0] = k[1] ^ k[0];
			nv[9][0] = k[1] ^ ~k[0];
			nvm_image_in <= {nv[9], nv[8], nv[7], nv[6], nv[5], nv[4],
				nv[3], nv[2], nv[1], nv[0]};
			hardwired_addr_pins_in <= $urandom;
			srst_in <= 1'b1;
			tick(4);
			srst_in <= 1'b0;
			tick(1);
			while (params_ready_out !== 1'b1) tick(1);
			tick(3);
			m_bank = nv[1][7];
			r[15:0] = m_bank ? {nv[8], nv[9]} : {nv[5], nv[6]};
			m_safe = {r[15:13], r[7:2], 2'b00};
			m_sleep = r[0];
			m_addr = nv[2][3:0];
			p = {2'b00, nv[5][4], nv[7][3:2], nv[7][6:4], nv[2][7:4],
				nv[5][3:0], nv[4], nv[3]};
			check_all;
			for (i = 4; i < 10; i++) begin
				wr(8'h10, 4'hF, i);
				rd(8'h10);
				chk("nvrd", q[7:0], m_bank && (i == 5 || i == 6) ?
					nv[i + 3] : nv[i]);
			end
			rd(8'h0C);
			chk("stat", {q[15:8], q[3:0]}, {1'b0, m_addr[3:0],
				hardwired_addr_pins_in, m_bank[0], r[1], m_sleep[0],
				1'b1});
			bus_timeout_in <= 1'b1;
			tick(3);
			chk("tmo", sleep_req_out, m_sleep);
			bus_timeout_in <= 1'b0;
			bus_err_ovf_in <= 1'b1;
			tick(3);
			chk("goto", goto_target_out, m_safe[10:2] != 9'h100);
			chk("hold", hold_in_place_out, m_safe[10:2] == 9'h100);
			bus_err_ovf_in <= 1'b0;
			sleep_cmd_in <= 1'b1;
			tick(3);
			chk("slp", sleep_req_out, m_sleep);
			chk("stop", stop_req_out, !m_sleep);
			sleep_cmd_in <= 1'b0;
			goto_safe_position_in <= 1'b1;
			tick(3);
			chk("gcmd", goto_target_out, 1'b1);
			goto_safe_position_in <= 1'b0;
			standby_state_in <= 1'b1;
			bus_timeout_in <= 1'b1;
			tick(3);
			chk("stby", sleep_req_out, 1'b1);
			standby_state_in <= 1'b0;
			bus_timeout_in <= 1'b0;
			$display("load test %0d done", k);
		end
		// Bus overwrites, partial lanes, safe position, unmapped place
		wr(8'h00, 4'hF, 32'h1);
		m_boost = 1;
		wr(8'h04, 4'hF, $urandom);
		tick(2);
		check_all;
		wr(8'h04, 4'h2, $urandom);
		r = $urandom;
		wr(8'h08, 4'h3, r);
		m_safe = r[10:0];
		wr(8'h1C, 4'hF, $urandom);
		rd(8'h1C);
		chk("unmap", q, 32'h0);
		check_all;
		$display("bus write test done");
		// Stop with zero hold, then with a real hold code
		r[7:0] = 8'hAF;
		wr(8'h04, 4'h1, r);
		seen = 0;
		motion_stop_in <= 1'b1;
		repeat (12) begin
			tick(1);
			if (coil_amp_code_out === 4'h0 && regulator_on_out === 1'b1)
				seen = 1;
		end
		chk("min", seen, 1);
		chk("regoff", regulator_on_out, 1'b0);
		chk("gnd", low_side_ground_out, 1'b1);
		motion_stop_in <= 1'b0;
		tick(3);
		chk("run", coil_amp_code_out, p[7:4]);
		r[3:0] = 4'h5;
		wr(8'h04, 4'h1, r);
		motion_stop_in <= 1'b1;
		tick(12);
		chk("hamp", coil_amp_code_out, 4'h5);
		chk("hreg", regulator_on_out, 1'b1);
		chk("hgnd", low_side_ground_out, 1'b0);
		$display("stop test done");
		results;
	end

	// Hang guard: the whole run needs well under 3000 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			results;
		end
	end

	// Counts and verdict, then end of run
	task results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
endmodule
